/* core/cfod_consts.vh */
/*
 * Shared constants of the flag and operand datapath: flag register layout,
 * operation codes, addressing mode codes and reset values.
 * Assumes inclusion by bare name from the core files.
 */
`ifndef CFOD_CONSTS_VH
`define CFOD_CONSTS_VH

// flag register bit positions
`define CFOD_FLAG_C 7
`define CFOD_FLAG_Z 6
`define CFOD_FLAG_S 5
`define CFOD_FLAG_V 4
`define CFOD_FLAG_D 3
`define CFOD_FLAG_H 2
`define CFOD_FLAG_USER 1
`define CFOD_FLAG_PD 0
`define CFOD_FLAGS_RST 8'h00

// operation codes
`define CFOD_OP_W 5
`define CFOD_OP_NOP 5'h00
`define CFOD_OP_ADD 5'h01
`define CFOD_OP_ADC 5'h02
`define CFOD_OP_SUB 5'h03
`define CFOD_OP_SBC 5'h04
`define CFOD_OP_AND 5'h05
`define CFOD_OP_OR 5'h06
`define CFOD_OP_XOR 5'h07
`define CFOD_OP_CP 5'h08
`define CFOD_OP_TM 5'h09
`define CFOD_OP_TCM 5'h0a
`define CFOD_OP_SLA 5'h0b
`define CFOD_OP_SRA 5'h0c
`define CFOD_OP_RRC 5'h0d
`define CFOD_OP_RLC 5'h0e
`define CFOD_OP_PUSH 5'h0f
`define CFOD_OP_POP 5'h10
`define CFOD_OP_LD 5'h11
`define CFOD_OP_LDIMM_LIDX 5'h12
`define CFOD_OP_LD_PI 5'h13
`define CFOD_OP_SPM 5'h14
`define CFOD_OP_SDM 5'h15
`define CFOD_OP_FLAGLD 5'h16
`define CFOD_OP_BIT 5'h17

// boolean bit functions
`define CFOD_BIT_SET 2'h0
`define CFOD_BIT_RES 2'h1
`define CFOD_BIT_CPL 2'h2
`define CFOD_BIT_LD 2'h3

// addressing modes
`define CFOD_AM_W 3
`define CFOD_AM_IND 3'h0
`define CFOD_AM_POSTINC 3'h1
`define CFOD_AM_PREDEC 3'h2
`define CFOD_AM_IDX_SHORT 3'h3
`define CFOD_AM_IDX_LONG 3'h4
`define CFOD_AM_IDX_REG 3'h5
`define CFOD_AM_DIRECT 3'h6
`define CFOD_AM_MAP2MAP 3'h7

`endif

/* core/cfod_addr_gen.v */
/*
 * Effective address and pointer update for one memory operand.
 * Assumes the caller registers the results; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cfod_consts.vh"

module cfod_addr_gen (
    // operand description
    input wire [2:0] mode,
    input wire [15:0] ptr,
    input wire [15:0] offset,
    input wire wide,
    // results
    output reg [15:0] ea,
    output reg [15:0] ptrNext,
    output reg ptrUpd
);
    wire [15:0] step = wide ? 16'h0002 : 16'h0001;

    always @* begin
        ea = ptr;
        ptrNext = ptr;
        ptrUpd = 1'b0;
        if (mode == `CFOD_AM_POSTINC || mode == `CFOD_AM_MAP2MAP) begin
            ptrNext = ptr + step;
            ptrUpd = 1'b1;
        end else if (mode == `CFOD_AM_PREDEC) begin
            ea = ptr - step;
            ptrNext = ptr - step;
            ptrUpd = 1'b1;
        end else if (mode == `CFOD_AM_IDX_SHORT) begin
            ea = ptr + {8'h00, offset[7:0]};
        end else if (mode == `CFOD_AM_IDX_LONG || mode == `CFOD_AM_IDX_REG) begin
            ea = ptr + offset;
        end else if (mode == `CFOD_AM_DIRECT) begin
            ea = offset;
        end
    end
endmodule
`default_nettype wire

/* core/cfod_datapath.v */
/*
 * Flag update and operand addressing datapath of the 8/16-bit core.
 * Assumes the sequencer presents one operation per opStart pulse with its
 * operands already fetched, and writes results back from the outputs.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cfod_consts.vh"

module cfod_datapath (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // operation request
    input wire opStart,
    input wire [4:0] opCode,
    input wire opWide,
    input wire [15:0] srcA,
    input wire [15:0] srcB,
    input wire [2:0] bitNum,
    input wire [1:0] bitFn,
    // addressing request
    input wire [2:0] addrMode,
    input wire [15:0] ptrIn,
    input wire [15:0] addrOffset,
    input wire [15:0] ptr2In,
    input wire instSpaceSrc,
    input wire instSpaceDst,
    // results
    output reg [15:0] result_r,
    output reg resultWr_r,
    output reg [7:0] flags_r,
    output reg opDone_r,
    output reg opRefused_r,
    // memory addressing
    output reg [15:0] memAddr_r,
    output reg memSpace_r,
    output reg [15:0] memAddr2_r,
    output reg memSpace2_r,
    output reg [15:0] ptrNew_r,
    output reg [15:0] ptr2New_r,
    output reg ptrWr_r,
    output reg pdPin_r
);
    // operand views at the selected width
    wire [15:0] opA = opWide ? srcA : {8'h00, srcA[7:0]};
    wire [15:0] opB = opWide ? srcB : {8'h00, srcB[7:0]};
    wire carryIn = flags_r[`CFOD_FLAG_C];
    wire isSub = (opCode == `CFOD_OP_SUB) || (opCode == `CFOD_OP_SBC) ||
                 (opCode == `CFOD_OP_CP);
    wire useCarry = (opCode == `CFOD_OP_ADC) || (opCode == `CFOD_OP_SBC);
    wire cin = useCarry ? carryIn : 1'b0;

    // adder shared by add, subtract, compare
    wire [16:0] sumFull = {1'b0, opA} + {1'b0, opB} + {16'h0000, cin};
    wire [16:0] difFull = {1'b0, opA} - {1'b0, opB} - {16'h0000, cin};
    wire [16:0] arith = isSub ? difFull : sumFull;
    // nibble carry for BCD work in byte form
    wire [4:0] nibSum = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
    wire [4:0] nibDif = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, cin};
    wire nibCarry = isSub ? nibDif[4] : nibSum[4];

    wire msbA = opWide ? opA[15] : opA[7];
    wire msbB = opWide ? opB[15] : opB[7];

    // effective addresses
    wire [15:0] eaMain;
    wire [15:0] eaSecond;
    wire [15:0] ptrNextMain;
    wire [15:0] ptrNextSecond;
    wire ptrUpdMain;

    cfod_addr_gen uAddrMain (
        .mode(addrMode),
        .ptr(ptrIn),
        .offset(addrOffset),
        .wide(opWide),
        .ea(eaMain),
        .ptrNext(ptrNextMain),
        .ptrUpd(ptrUpdMain)
    );

    cfod_addr_gen uAddrSecond (
        .mode(addrMode),
        .ptr(ptr2In),
        .offset(addrOffset),
        .wide(opWide),
        .ea(eaSecond),
        .ptrNext(ptrNextSecond),
        .ptrUpd()
    );

    reg [15:0] res_nxt;
    reg resWr_nxt;
    reg [7:0] flags_nxt;
    reg refuse_nxt;
    reg msbRes;
    reg zeroRes;
    reg [7:0] bitMask;

    always @* begin
        res_nxt = result_r;
        resWr_nxt = 1'b0;
        flags_nxt = flags_r;
        refuse_nxt = 1'b0;
        msbRes = 1'b0;
        zeroRes = 1'b0;
        bitMask = 8'h01 << bitNum;
        if (opStart) begin
            case (opCode)
                `CFOD_OP_ADD, `CFOD_OP_ADC, `CFOD_OP_SUB, `CFOD_OP_SBC, `CFOD_OP_CP: begin
                    res_nxt = opWide ? arith[15:0] : {8'h00, arith[7:0]};
                    resWr_nxt = (opCode != `CFOD_OP_CP);
                    msbRes = opWide ? arith[15] : arith[7];
                    zeroRes = opWide ? (arith[15:0] == 16'h0000) : (arith[7:0] == 8'h00);
                    flags_nxt[`CFOD_FLAG_C] = opWide ? arith[16] : (arith[8] ^ 1'b0);
                    flags_nxt[`CFOD_FLAG_Z] = zeroRes;
                    flags_nxt[`CFOD_FLAG_S] = msbRes;
                    flags_nxt[`CFOD_FLAG_V] = isSub ? ((msbA ^ msbB) & (msbA ^ msbRes)) :
                                                      (~(msbA ^ msbB) & (msbA ^ msbRes));
                    if (!opWide && opCode != `CFOD_OP_CP) begin
                        flags_nxt[`CFOD_FLAG_D] = isSub;
                        flags_nxt[`CFOD_FLAG_H] = nibCarry;
                    end
                end
                `CFOD_OP_AND, `CFOD_OP_OR, `CFOD_OP_XOR, `CFOD_OP_TM, `CFOD_OP_TCM: begin
                    if (opCode == `CFOD_OP_AND || opCode == `CFOD_OP_TM) begin
                        res_nxt = opA & opB;
                    end else if (opCode == `CFOD_OP_OR) begin
                        res_nxt = opA | opB;
                    end else if (opCode == `CFOD_OP_XOR) begin
                        res_nxt = opA ^ opB;
                    end else begin
                        res_nxt = (~opA) & opB;
                    end
                    if (!opWide) begin
                        res_nxt[15:8] = 8'h00;
                    end
                    // test forms only set flags
                    resWr_nxt = (opCode != `CFOD_OP_TM) && (opCode != `CFOD_OP_TCM);
                    // carry, D and H held
                    flags_nxt[`CFOD_FLAG_Z] = opWide ? (res_nxt == 16'h0000) :
                                                       (res_nxt[7:0] == 8'h00);
                    flags_nxt[`CFOD_FLAG_S] = opWide ? res_nxt[15] : res_nxt[7];
                    flags_nxt[`CFOD_FLAG_V] = 1'b0;
                end
                `CFOD_OP_SLA: begin
                    res_nxt = opWide ? {opA[14:0], 1'b0} : {8'h00, opA[6:0], 1'b0};
                    resWr_nxt = 1'b1;
                    msbRes = opWide ? opA[14] : opA[6];
                    flags_nxt[`CFOD_FLAG_C] = msbA;
                    flags_nxt[`CFOD_FLAG_Z] = (res_nxt == 16'h0000);
                    flags_nxt[`CFOD_FLAG_S] = msbRes;
                    flags_nxt[`CFOD_FLAG_V] = msbA ^ msbRes;
                    if (!opWide) begin
                        flags_nxt[`CFOD_FLAG_H] = opA[3];
                        flags_nxt[`CFOD_FLAG_D] = 1'b0;
                    end
                end
                `CFOD_OP_SRA: begin
                    res_nxt = opWide ? {opA[15], opA[15:1]} : {8'h00, opA[7], opA[7:1]};
                    resWr_nxt = 1'b1;
                    flags_nxt[`CFOD_FLAG_C] = opA[0];
                    flags_nxt[`CFOD_FLAG_S] = msbA;
                    flags_nxt[`CFOD_FLAG_V] = 1'b0;
                    if (!opWide) begin
                        flags_nxt[`CFOD_FLAG_Z] = (res_nxt == 16'h0000);
                        flags_nxt[`CFOD_FLAG_H] = opA[4];
                        flags_nxt[`CFOD_FLAG_D] = 1'b0;
                    end
                end
                `CFOD_OP_RRC: begin
                    res_nxt = opWide ? {carryIn, opA[15:1]} : {8'h00, carryIn, opA[7:1]};
                    resWr_nxt = 1'b1;
                    flags_nxt[`CFOD_FLAG_C] = opA[0];
                    flags_nxt[`CFOD_FLAG_S] = carryIn;
                    flags_nxt[`CFOD_FLAG_V] = carryIn ^ msbA;
                    if (!opWide) begin
                        flags_nxt[`CFOD_FLAG_Z] = (res_nxt == 16'h0000);
                    end
                end
                `CFOD_OP_RLC: begin
                    res_nxt = opWide ? {opA[14:0], carryIn} : {8'h00, opA[6:0], carryIn};
                    resWr_nxt = 1'b1;
                    msbRes = opWide ? opA[14] : opA[6];
                    flags_nxt[`CFOD_FLAG_C] = msbA;
                    flags_nxt[`CFOD_FLAG_S] = msbRes;
                    flags_nxt[`CFOD_FLAG_V] = msbA ^ msbRes;
                    if (!opWide) begin
                        flags_nxt[`CFOD_FLAG_Z] = (res_nxt == 16'h0000);
                    end
                end
                `CFOD_OP_PUSH, `CFOD_OP_POP, `CFOD_OP_LD: begin
                    res_nxt = opA; // flags held
                    resWr_nxt = 1'b1;
                end
                `CFOD_OP_LDIMM_LIDX, `CFOD_OP_LD_PI: begin
                    if (opWide) begin
                        refuse_nxt = 1'b1;
                    end else begin
                        res_nxt = opA;
                        resWr_nxt = 1'b1;
                    end
                end
                `CFOD_OP_SPM: begin
                    flags_nxt[`CFOD_FLAG_PD] = 1'b0;
                end
                `CFOD_OP_SDM: begin
                    flags_nxt[`CFOD_FLAG_PD] = 1'b1;
                end
                `CFOD_OP_FLAGLD: begin
                    flags_nxt = srcA[7:0];
                end
                `CFOD_OP_BIT: begin
                    // any bit of any register byte, flags held
                    res_nxt = {8'h00, srcA[7:0]};
                    if (bitFn == `CFOD_BIT_SET) begin
                        res_nxt[7:0] = srcA[7:0] | bitMask;
                    end else if (bitFn == `CFOD_BIT_RES) begin
                        res_nxt[7:0] = srcA[7:0] & ~bitMask;
                    end else if (bitFn == `CFOD_BIT_CPL) begin
                        res_nxt[7:0] = srcA[7:0] ^ bitMask;
                    end else begin
                        res_nxt[7:0] = srcB[bitNum] ? (srcA[7:0] | bitMask) :
                                                      (srcA[7:0] & ~bitMask);
                    end
                    resWr_nxt = 1'b1;
                end
                default: begin
                    res_nxt = result_r;
                end
            endcase
        end
    end

    // registered outputs
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            result_r <= 16'h0000;
            resultWr_r <= 1'b0;
            flags_r <= `CFOD_FLAGS_RST;
            opDone_r <= 1'b0;
            opRefused_r <= 1'b0;
            memAddr_r <= 16'h0000;
            memSpace_r <= 1'b0;
            memAddr2_r <= 16'h0000;
            memSpace2_r <= 1'b0;
            ptrNew_r <= 16'h0000;
            ptr2New_r <= 16'h0000;
            ptrWr_r <= 1'b0;
            pdPin_r <= 1'b0;
        end else begin
            result_r <= res_nxt;
            resultWr_r <= resWr_nxt;
            flags_r <= flags_nxt;
            opDone_r <= opStart;
            opRefused_r <= refuse_nxt;
            pdPin_r <= flags_nxt[`CFOD_FLAG_PD];
            ptrWr_r <= opStart & ptrUpdMain & ~refuse_nxt;
            if (opStart) begin
                memAddr_r <= eaMain;
                memAddr2_r <= eaSecond;
                ptrNew_r <= ptrNextMain;
                ptr2New_r <= ptrNextSecond;
                if (addrMode == `CFOD_AM_MAP2MAP) begin
                    memSpace_r <= instSpaceSrc;
                    memSpace2_r <= instSpaceDst;
                end else begin
                    memSpace_r <= flags_r[`CFOD_FLAG_PD];
                    memSpace2_r <= flags_r[`CFOD_FLAG_PD];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/cfod_datapath_assertions.sv */
/*
 * Port-level assertions for the flag and operand datapath.
 * Assumes it is bound onto cfod_datapath, single clock clk_sys, reset rst_n.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cfod_consts.vh"

module cfod_datapath_assertions (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // request
    input wire logic opStart,
    input wire logic [4:0] opCode,
    input wire logic opWide,
    input wire logic [2:0] addrMode,
    input wire logic instSpaceSrc,
    input wire logic instSpaceDst,
    // results
    input wire logic resultWr_r,
    input wire logic [7:0] flags_r,
    input wire logic opDone_r,
    input wire logic opRefused_r,
    input wire logic memSpace_r,
    input wire logic memSpace2_r,
    input wire logic ptrWr_r,
    input wire logic pdPin_r
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    wire logic isLogic;
    wire logic isMask;
    wire logic isLd;
    wire logic isByteOnly;
    assign isLogic = opStart && (opCode == `CFOD_OP_AND || opCode == `CFOD_OP_OR
        || opCode == `CFOD_OP_XOR);
    assign isMask = opStart && (opCode == `CFOD_OP_TM || opCode == `CFOD_OP_TCM);
    assign isLd = opStart && opCode == `CFOD_OP_LD;
    assign isByteOnly = opStart && (opCode == `CFOD_OP_LDIMM_LIDX || opCode == `CFOD_OP_LD_PI);

    a_done_follows: assert property (opStart |=> opDone_r)
        else $error("done pulse missing after request");
    a_no_done_idle: assert property (!opStart |=> !opDone_r)
        else $error("done pulse without request");
    a_logic_keeps_c: assert property (isLogic
        |=> flags_r[7] == $past(flags_r[7]) && !flags_r[4])
        else $error("logic op touched carry or left overflow set");
    a_mask_keeps_flags: assert property (isMask |=> !flags_r[4] && !resultWr_r
        && flags_r[7] == $past(flags_r[7]) && flags_r[3:2] == $past(flags_r[3:2]))
        else $error("mask test changed kept flags");
    a_stack_no_flags: assert property (opStart && (opCode == `CFOD_OP_PUSH
        || opCode == `CFOD_OP_POP) |=> $stable(flags_r) && pdPin_r == flags_r[0])
        else $error("stack op changed flags");
    a_word_sra_flags: assert property (opStart && opWide && opCode == `CFOD_OP_SRA
        |=> !flags_r[4] && flags_r[3:2] == $past(flags_r[3:2]))
        else $error("word right shift flags wrong");
    a_byte_shift_dclr: assert property (opStart && !opWide
        && (opCode == `CFOD_OP_SLA || opCode == `CFOD_OP_SRA) |=> !flags_r[3])
        else $error("byte shift left decimal flag set");
    a_space_from_flag: assert property (isLd && addrMode != `CFOD_AM_MAP2MAP
        |=> memSpace_r == $past(flags_r[0]))
        else $error("memory space differs from select flag");
    a_map_spaces: assert property (isLd && addrMode == `CFOD_AM_MAP2MAP |=> ptrWr_r
        && memSpace_r == $past(instSpaceSrc) && memSpace2_r == $past(instSpaceDst))
        else $error("map to map spaces wrong");
    a_word_refused: assert property (isByteOnly && opWide
        |=> opRefused_r && !resultWr_r && !ptrWr_r && $stable(flags_r))
        else $error("word form of byte load not refused");
    a_pd_set: assert property (opStart && opCode == `CFOD_OP_SDM
        |=> flags_r[0] && pdPin_r)
        else $error("data space select not shown");

    c_refused: cover property (isByteOnly && opWide ##1 opRefused_r);
    c_map: cover property (isLd && addrMode == `CFOD_AM_MAP2MAP);
    c_back_to_back: cover property (opStart ##1 opStart && opDone_r);
endmodule
`default_nettype wire

/* testbench/test_cpu_flag_and_operand_datapath.sv */
/*
 * Self-checking bench for the flag and operand datapath.
 * Assumes cfod_datapath and cfod_datapath_assertions are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cfod_consts.vh"
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin fails++; \
    $display("unexpected at %0t: got %h want %h", $time, (g), (w)); end end

module test_cpu_flag_and_operand_datapath;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic opStart = 1'b0;
    logic opWide = 1'b0;
    logic instSpaceSrc = 1'b0;
    logic instSpaceDst = 1'b0;
    logic [4:0] opCode = 5'h00;
    logic [2:0] bitNum = 3'h0;
    logic [2:0] addrMode = 3'h0;
    logic [1:0] bitFn = 2'h0;
    logic [15:0] srcA = 16'h0000, srcB = 16'h0000, ptrIn = 16'h1000;
    logic [15:0] addrOffset = 16'h0120, ptr2In = 16'h3000;
    wire logic [15:0] result_r, memAddr_r, memAddr2_r, ptrNew_r, ptr2New_r;
    wire logic [7:0] flags_r;
    wire logic resultWr_r, opDone_r, opRefused_r, memSpace_r, memSpace2_r, ptrWr_r, pdPin_r;
    logic pWr, pRef, pPtr;
    int fails = 0;
    int checks_done = 0;

    always #10 clk_sys = ~clk_sys;

    cfod_datapath cfod_datapath_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .opStart(opStart), .opCode(opCode), .opWide(opWide),
        .srcA(srcA), .srcB(srcB), .bitNum(bitNum), .bitFn(bitFn), .addrMode(addrMode),
        .ptrIn(ptrIn), .addrOffset(addrOffset), .ptr2In(ptr2In), .instSpaceSrc(instSpaceSrc),
        .instSpaceDst(instSpaceDst), .result_r(result_r), .resultWr_r(resultWr_r),
        .flags_r(flags_r), .opDone_r(opDone_r), .opRefused_r(opRefused_r),
        .memAddr_r(memAddr_r), .memSpace_r(memSpace_r), .memAddr2_r(memAddr2_r),
        .memSpace2_r(memSpace2_r), .ptrNew_r(ptrNew_r), .ptr2New_r(ptr2New_r),
        .ptrWr_r(ptrWr_r), .pdPin_r(pdPin_r)
    );

    // entered at a falling edge; last low keeps the request up for a back to back op
    task automatic go(input logic [4:0] c, input logic w, input logic [15:0] a, b,
        input logic last = 1'b1);
        opStart = 1'b1;
        opCode = c;
        opWide = w;
        srcA = a;
        srcB = b;
        @(negedge clk_sys);
        pWr = resultWr_r;
        pRef = opRefused_r;
        pPtr = ptrWr_r;
        if (last) begin
            opStart = 1'b0;
            @(negedge clk_sys);
        end
    endtask

    task automatic setf(input logic [7:0] v);
        go(`CFOD_OP_FLAGLD, 1'b0, {8'h00, v}, 16'h0000);
    endtask

    task automatic t_arith;
        go(`CFOD_OP_ADD, 1'b1, 16'h7fff, 16'h0001);
        `CHK({result_r, flags_r[7:4], pWr}, {16'h8000, 4'h3, 1'b1})
        go(`CFOD_OP_SUB, 1'b1, 16'h0000, 16'h0001);
        `CHK({result_r, flags_r[7:4]}, {16'hffff, 4'ha})
        go(`CFOD_OP_ADD, 1'b1, 16'hffff, 16'h0001, 1'b0);
        `CHK({result_r, flags_r[7:4]}, {16'h0000, 4'hc})
        go(`CFOD_OP_ADC, 1'b1, 16'h0001, 16'h0001);
        `CHK({result_r, flags_r[7:4]}, {16'h0003, 4'h0})
        go(`CFOD_OP_ADD, 1'b0, 16'h000f, 16'h0001);
        `CHK({result_r, flags_r[7:2]}, {16'h0010, 6'h01})
        go(`CFOD_OP_SUB, 1'b0, 16'h0010, 16'h0001);
        `CHK({result_r, flags_r[3]}, {16'h000f, 1'b1})
        go(`CFOD_OP_CP, 1'b1, 16'h0000, 16'h0001);
        `CHK({flags_r, pWr}, {8'hac, 1'b0})
        go(`CFOD_OP_SBC, 1'b0, 16'h0010, 16'h000f);
        `CHK({result_r, flags_r, pWr}, {16'h0000, 8'h4c, 1'b1})
        $display("test arith done");
    endtask

    task automatic t_logic;
        setf(8'h9c);
        go(`CFOD_OP_AND, 1'b1, 16'h00ff, 16'hff00);
        `CHK({result_r, flags_r[7:4]}, {16'h0000, 4'hc})
        go(`CFOD_OP_OR, 1'b1, 16'h8000, 16'h0001);
        `CHK({result_r, flags_r[7:4]}, {16'h8001, 4'ha})
        go(`CFOD_OP_XOR, 1'b1, 16'hffff, 16'h7fff);
        `CHK({result_r, flags_r[7:4]}, {16'h8000, 4'ha})
        setf(8'h9c);
        go(`CFOD_OP_TM, 1'b0, 16'h0080, 16'h0080);
        `CHK({flags_r, pWr}, {8'hac, 1'b0})
        go(`CFOD_OP_TM, 1'b1, 16'h0001, 16'h8000);
        `CHK(flags_r, 8'hcc)
        setf(8'h9c);
        go(`CFOD_OP_TCM, 1'b1, 16'hffff, 16'h8000);
        `CHK({flags_r, pWr}, {8'hcc, 1'b0})
        $display("test logic done");
    endtask

    task automatic t_shift;
        setf(8'h00);
        go(`CFOD_OP_SLA, 1'b0, 16'h0088, 16'h0000);
        `CHK({result_r, flags_r}, {16'h0010, 8'h94})
        go(`CFOD_OP_SLA, 1'b1, 16'h4000, 16'h0000);
        `CHK({result_r, flags_r[7:4]}, {16'h8000, 4'h3})
        go(`CFOD_OP_SRA, 1'b0, 16'h0081, 16'h0000);
        `CHK({result_r, flags_r}, {16'h00c0, 8'ha0})
        setf(8'h0c);
        go(`CFOD_OP_SRA, 1'b1, 16'h8001, 16'h0000);
        `CHK({result_r, flags_r[7], flags_r[5:2]}, {16'hc000, 5'h1b})
        setf(8'h80);
        go(`CFOD_OP_RRC, 1'b0, 16'h0002, 16'h0000);
        `CHK({result_r, flags_r[7:5], flags_r[3:2]}, {16'h0081, 5'h04})
        setf(8'h8c);
        go(`CFOD_OP_RLC, 1'b1, 16'h8000, 16'h0000);
        `CHK({result_r, flags_r[7], flags_r[5], flags_r[3:2]}, {16'h0001, 4'hb})
        setf(8'h00);
        go(`CFOD_OP_RLC, 1'b0, 16'h0080, 16'h0000);
        `CHK({result_r, flags_r[7:6]}, {16'h0000, 2'b11})
        $display("test shift done");
    endtask

    task automatic t_stack;
        setf(8'h5a);
        go(`CFOD_OP_PUSH, 1'b1, 16'h1234, 16'h0000);
        `CHK({flags_r, pdPin_r}, {8'h5a, 1'b0})
        go(`CFOD_OP_POP, 1'b0, 16'h00ff, 16'h0000);
        `CHK({flags_r, pdPin_r}, {8'h5a, 1'b0})
        go(`CFOD_OP_NOP, 1'b0, 16'h1234, 16'h0000);
        `CHK({result_r, flags_r, pWr, pRef}, {16'h00ff, 8'h5a, 2'b00})
        $display("test stack done");
    endtask

    task automatic t_modes;
        logic [15:0] eaWant [7];
        eaWant = '{16'h1000, 16'h1000, 16'h0fff, 16'h1020, 16'h1120, 16'h1120, 16'h0120};
        for (int i = 0; i < 7; i++) begin
            addrMode = i[2:0];
            go(`CFOD_OP_LD, 1'b0, 16'h0000, 16'h0000);
            `CHK({memAddr_r, pPtr}, {eaWant[i], i == 1 || i == 2})
        end
        addrMode = `CFOD_AM_POSTINC;
        go(`CFOD_OP_LD, 1'b1, 16'h0000, 16'h0000);
        `CHK({memAddr_r, ptrNew_r}, {16'h1000, 16'h1002})
        addrMode = `CFOD_AM_PREDEC;
        go(`CFOD_OP_LD, 1'b1, 16'h0000, 16'h0000);
        `CHK({memAddr_r, ptrNew_r}, {16'h0ffe, 16'h0ffe})
        $display("test modes done");
    endtask

    task automatic t_space;
        go(`CFOD_OP_SDM, 1'b0, 16'h0000, 16'h0000);
        `CHK({flags_r[0], pdPin_r}, 2'b11)
        addrMode = `CFOD_AM_IND;
        go(`CFOD_OP_LD, 1'b0, 16'h0000, 16'h0000);
        `CHK({memSpace_r, memAddr_r}, {1'b1, 16'h1000})
        addrMode = `CFOD_AM_MAP2MAP;
        instSpaceDst = 1'b1;
        go(`CFOD_OP_LD, 1'b0, 16'h0000, 16'h0000);
        `CHK({memSpace_r, memSpace2_r, pPtr}, 3'b011)
        `CHK({ptrNew_r, ptr2New_r, memAddr2_r}, {32'h10013001, 16'h3000})
        go(`CFOD_OP_SPM, 1'b0, 16'h0000, 16'h0000);
        instSpaceSrc = 1'b1;
        instSpaceDst = 1'b0;
        go(`CFOD_OP_LD, 1'b0, 16'h0000, 16'h0000);
        `CHK({pdPin_r, memSpace_r, memSpace2_r}, 3'b010)
        addrMode = `CFOD_AM_IND;
        go(`CFOD_OP_LD, 1'b0, 16'h0000, 16'h0000);
        `CHK(memSpace_r, 1'b0)
        $display("test space done");
    endtask

    task automatic t_refuse;
        setf(8'h33);
        addrMode = `CFOD_AM_IDX_LONG;
        go(`CFOD_OP_LDIMM_LIDX, 1'b1, 16'h1234, 16'h0000);
        `CHK({pRef, pWr, pPtr, flags_r}, {3'b100, 8'h33})
        go(`CFOD_OP_LDIMM_LIDX, 1'b0, 16'h1234, 16'h0000);
        `CHK({pRef, pWr}, 2'b01)
        addrMode = `CFOD_AM_POSTINC;
        go(`CFOD_OP_LD_PI, 1'b1, 16'h0000, 16'h0000);
        `CHK({pRef, pWr, pPtr, flags_r}, {3'b100, 8'h33})
        go(`CFOD_OP_LD_PI, 1'b0, 16'h0000, 16'h0000);
        `CHK({pRef, pPtr}, 2'b01)
        $display("test refuse done");
    endtask

    task automatic t_bits;
        logic [7:0] m, want;
        for (int n = 0; n < 8; n++) begin
            for (int f = 0; f < 4; f++) begin
                m = 8'h01 << n;
                want = f == 0 ? 8'h5a | m : f == 1 ? 8'h5a & ~m : f == 2 ? 8'h5a ^ m
                    : (8'h5a & ~m) | (8'ha5 & m);
                bitNum = n[2:0];
                bitFn = f[1:0];
                go(`CFOD_OP_BIT, 1'b0, 16'h005a, 16'h00a5);
                `CHK(result_r[7:0], want)
                `CHK(flags_r, 8'h33)
            end
        end
        $display("test bits done");
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clk_sys);
        fails++;
        give_verdict();
    end

    initial begin
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        `CHK({flags_r, opDone_r, resultWr_r, pdPin_r}, {`CFOD_FLAGS_RST, 3'b000})
        $display("test reset done");
        t_arith();
        t_logic();
        t_shift();
        t_stack();
        t_modes();
        t_space();
        t_refuse();
        t_bits();
        give_verdict();
    end
endmodule

bind cfod_datapath cfod_datapath_assertions cfod_datapath_assertions_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .opStart(opStart), .opCode(opCode), .opWide(opWide),
    .addrMode(addrMode), .instSpaceSrc(instSpaceSrc), .instSpaceDst(instSpaceDst),
    .resultWr_r(resultWr_r), .flags_r(flags_r), .opDone_r(opDone_r),
    .opRefused_r(opRefused_r), .memSpace_r(memSpace_r), .memSpace2_r(memSpace2_r),
    .ptrWr_r(ptrWr_r), .pdPin_r(pdPin_r)
);
`default_nettype wire
